// ---- bench/i2c_other_master.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2c_other_master (
    input wire logic mclk,
    input wire logic scl,
    input wire logic sda,
    input wire logic [1:0] mode,
    output var logic scl_low,
    output var logic sda_low
);
    logic [3:0] cnt;
    // ==========================================================
    // 0 quiet, 1 sends a zero, 2 stretches clock early, 3 short data dip
    always @(posedge mclk) begin
        if (mode == 2'h0) begin
            cnt <= 4'h0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            if (mode == 2'h1) cnt <= cnt + 4'(!scl && sda && cnt != 4'hF);
            else cnt <= scl ? cnt + 4'(cnt != 4'hF) : 4'h0;
            if (mode == 2'h1 && cnt == 4'h6) sda_low <= 1'b1;
            if (mode == 2'h2 && cnt == 4'h4) scl_low <= 1'b1;
            if (mode == 2'h3) sda_low <= cnt >= 4'h4 && cnt < 4'h8;
        end
    end
endmodule : i2c_other_master

`default_nettype wire

// ---- bench/ssp_ctl3_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module ssp_ctl3_chk
    import ssp_ctl3_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic SPI_SCK,
    input wire logic SPI_SDI,
    input wire logic START_IRQ,
    input wire logic STOP_IRQ,
    input wire logic BUS_COLLISION
);
    // Software clearing the collision flag
    wire clr = WR && ADDR == REG_STAT && WDATA[STAT_BCL];
    // Mode writes leaving I2C master mode can release both lines in one cycle
    wire wr_ctrl = WR && ADDR == REG_CTRL;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // ==========================================================
    // Line drive, interrupt pulses, collision handling, ack phase read
    open_drain_a: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
        else $error("line data output not zero");
    start_pulse_a: assert property (START_IRQ |=> !START_IRQ)
        else $error("start interrupt longer than one cycle");
    stop_pulse_a: assert property (STOP_IRQ |=> !STOP_IRQ)
        else $error("stop interrupt longer than one cycle");
    coll_release_a: assert property ($rose(BUS_COLLISION) |-> ##2 (!SDA_OE && !SCL_OE) [*4])
        else $error("lines still driven after collision");
    coll_sticky_a: assert property (BUS_COLLISION && !clr && !$past(clr) |=> BUS_COLLISION)
        else $error("collision flag lost without clear");
    rs_order_a: assert property ($rose(SCL_OE) && SDA_OE |-> $past(SDA_OE))
        else $error("clock pulled low before data");
    scl_late_a: assert property ($fell(SCL_OE) && !SDA_OE && !$past(wr_ctrl, 2) |-> $past(SDA_OE, 4) == 1'b0)
        else $error("clock released too soon after data");
    ack_gate_a: assert property (RD && ADDR == REG_CTL3 |=> !(RDATA[7] && RDATA[1:0] == 2'b00))
        else $error("ack phase bit set with holds disabled");
endmodule : ssp_ctl3_chk

bind serial_port_ctl3_rstart_collision ssp_ctl3_chk i_ssp_ctl3_chk (.MCLK(MCLK), .ARST_N(ARST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(SCL_I), .SCL_O(SCL_O),
    .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SPI_SCK(SPI_SCK), .SPI_SDI(SPI_SDI),
    .START_IRQ(START_IRQ), .STOP_IRQ(STOP_IRQ), .BUS_COLLISION(BUS_COLLISION));

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench
    import ssp_ctl3_pkg::*;
;
    logic mclk, arst_n, wr, rd, sck, sdi, rd_seen, bscl, bsda;
    logic [2:0] addr;
    logic [7:0] wdata, x, y;
    logic [1:0] pm;
    wire [7:0] rdata;
    wire scl_oe, sda_oe, start_irq, stop_irq, coll, p_scl, p_sda;
    wire scl = !(scl_oe || p_scl || bscl);
    wire sda = !(sda_oe || p_sda || bsda);
    int errors, n_checks, n_start, n_stop, n;
    logic [7:0] exp_q[$];

    // ==========================================================
    // Design, far side, clock
    serial_port_ctl3_rstart_collision i_serial_port_ctl3_rstart_collision (.MCLK(mclk), .ARST_N(arst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
        .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .SPI_SCK(sck), .SPI_SDI(sdi), .START_IRQ(start_irq),
        .STOP_IRQ(stop_irq), .BUS_COLLISION(coll));
    i2c_other_master i_i2c_other_master (.mclk(mclk), .scl(scl), .sda(sda), .mode(pm), .scl_low(p_scl),
        .sda_low(p_sda));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ==========================================================
    // Bus tasks and comparison
    task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wrr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wrr
    task rdr(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rdr
    task spi(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            sdi <= b[i];
            sck <= 1'b0;
            repeat (4) @(posedge mclk);
            sck <= 1'b1;
            repeat (3) @(posedge mclk);
        end
        @(posedge mclk);
        sck <= 1'b0;
        sdi <= ~b[0];
        repeat (6) @(posedge mclk);
    endtask : spi
    // One I2C clock from the bench master: data set while SCL low
    task i2c_clk(input logic low);
        repeat (8) @(posedge mclk);
        bsda <= low;
        repeat (8) @(posedge mclk);
        bscl <= 1'b0;
        repeat (8) @(posedge mclk);
        bscl <= 1'b1;
    endtask : i2c_clk
    task report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // Read data monitor and start and stop interrupt counters
    always @(negedge mclk) begin
        if (rd_seen && exp_q.size() > 0) chk("RDATA", exp_q.pop_front(), rdata);
        rd_seen = rd;
        if (start_irq === 1'b1) n_start++;
        if (stop_irq === 1'b1) n_stop++;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {arst_n, wr, rd, sck, sdi, rd_seen, bscl, bsda} = '0;
        addr = 3'h0;
        wdata = 8'h00;
        pm = 2'h0;
        void'($urandom(32'h56d3));
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        // Reset values, read-only bit, unmapped place
        rdr(REG_CTL3, CTL3_RESET);
        rdr(REG_STAT, 8'h04);
        x = 8'($urandom);
        wrr(REG_CTL3, x);
        rdr(REG_CTL3, x & 8'h7F);
        wrr(3'h6, x);
        rdr(3'h6, 8'h00);
        // Repeated Start: clean, zero sent, clock stolen, short data dip
        for (int m = 0; m < 4; m++) begin
            wrr(REG_CTL3, 8'h60);
            wrr(REG_BAUD, 8'h0C);
            wrr(REG_CTRL, 8'h00);
            n_start = 0;
            n_stop = 0;
            wrr(REG_CTRL, 8'h08);
            pm <= m[1:0];
            repeat (4) @(posedge mclk);
            for (n = 0; n < 300 && !coll && !(sda_oe && scl_oe); n++) @(posedge mclk);
            repeat (3) @(posedge mclk);
            chk("BUS_COLLISION", 8'(m == 1 || m == 2), 8'(coll));
            chk("line drive", (m == 0 || m == 3) ? 8'h03 : 8'h00, {6'h0, sda_oe, scl_oe});
            if (m == 0 || m == 3) chk("START_IRQ count", (m == 0) ? 8'h01 : 8'h02, 8'(n_start));
            if (m == 0 || m == 3) chk("STOP_IRQ count", (m == 0) ? 8'h00 : 8'h01, 8'(n_stop));
            pm <= 2'h0;
            wrr(REG_STAT, 8'h0C);
            repeat (3) @(posedge mclk);
            chk("BUS_COLLISION", 8'h00, 8'(coll));
        end
        // Receiver overrun with and without overwrite
        wrr(REG_CTRL, 8'h03);
        for (int b = 0; b < 2; b++) begin
            wrr(REG_CTL3, b ? 8'h10 : 8'h00);
            x = 8'($urandom);
            y = 8'($urandom);
            spi(x);
            spi(y);
            rdr(REG_STAT, 8'h07);
            rdr(REG_BUF, b ? y : x);
            wrr(REG_STAT, 8'h06);
        end
        // I2C slave: own address held and acknowledged, then released
        wrr(REG_CTRL, 8'h01);
        y = {x[6:0], 1'b0};
        wrr(REG_BAUD, y);
        wrr(REG_CTL3, 8'h02);
        bsda <= 1'b1;
        repeat (8) @(posedge mclk);
        bscl <= 1'b1;
        for (int i = 7; i >= 0; i--) i2c_clk(!y[i]);
        repeat (12) @(posedge mclk);
        bsda <= 1'b0;
        chk("line drive", 8'h03, {6'h0, sda_oe, scl_oe});
        rdr(REG_CTL3, 8'h82);
        rdr(REG_STAT, 8'h01);
        rdr(REG_BUF, y);
        wrr(REG_STAT, 8'h04);
        i2c_clk(1'b0);
        repeat (12) @(posedge mclk);
        chk("line drive", 8'h00, {6'h0, sda_oe, scl_oe});
        rdr(REG_CTL3, 8'h02);
        repeat (3) @(posedge mclk);
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire

// ---- common/ssp_ctl3_pkg.sv ----
// Summary of operation
// - Repeated Start: after SDA floats high, load generator, count down, release SCL.
// - SDA low once SCL reads high during Repeated Start means bus collision.
// - SDA high reloads the generator; SDA falling before expiry is no collision.
// - SCL falling before expiry while SDA not yet driven low is a collision.
// - Both high at expiry: drive SDA low, reload, then drive SCL low.
// - Acknowledge-time bit 7 sets on eighth SCL fall, clears on ninth rise.
// - Acknowledge-time bit works only while address or data hold is enabled.
// - Stop interrupt enable bit 6 gates the interrupt on a detected Stop.
// - Start interrupt enable bit 5 gates interrupt on Start or Repeated Start.
// - Start and stop enables do nothing in slave modes with built-in detection.
// - SPI slave with overwrite bit 4 set stores every byte, ignoring buffer-full.
// - SPI slave without overwrite: byte on full buffer sets overflow, buffer kept.
// - SPI slave with overwrite still sets overflow but stores the newest byte.
// - I2C master and SPI master modes ignore the overwrite enable bit.
// - I2C slave overwrite: update and acknowledge if buffer empty, else need no overflow.
// - SDA hold after SCL fall is 300 ns with bit 3 set, 100 ns clear.
// - I2C slave: SDA low on SCL rise while driving high sets collision, idles.
// - Address hold bit 1: clear clock release, hold SCL after matching address.
// - Data hold bit 0: clear clock release, hold SCL after received data byte.
`default_nettype none

package ssp_ctl3_pkg;

    // ==========================================================
    // Register indices and layout
    localparam logic [2:0] REG_CTL3 = 3'h0;
    localparam logic [2:0] REG_CTRL = 3'h1;
    localparam logic [2:0] REG_BAUD = 3'h2;
    localparam logic [2:0] REG_STAT = 3'h3;
    localparam logic [2:0] REG_BUF = 3'h4;

    localparam int CTL3_ACK_PHASE = 7;
    localparam int CTL3_STOP_IE = 6;
    localparam int CTL3_START_IE = 5;
    localparam int CTL3_BUFFER_OVERWRITE_ENABLE = 4;
    localparam int CTL3_SDA_HOLD_SELECT = 3;
    localparam int CTL3_SLAVE_COLLISION_ENABLE = 2;
    localparam int CTL3_ADDRESS_HOLD_ENABLE = 1;
    localparam int CTL3_DATA_HOLD_ENABLE = 0;

    localparam int CTRL_AUTO_SS = 2;
    localparam int CTRL_RS_GO = 3;

    localparam int STAT_BF = 0;
    localparam int STAT_OV = 1;
    localparam int STAT_CKP = 2;
    localparam int STAT_BCL = 3;
    localparam int STAT_RS_BUSY = 4;

    localparam logic [7:0] CTL3_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic CKP_RESET = 1'b1;

    // ==========================================================
    // Port modes
    typedef enum logic [1:0] {
        MODE_I2C_MASTER = 2'h0,
        MODE_I2C_SLAVE = 2'h1,
        MODE_SPI_MASTER = 2'h2,
        MODE_SPI_SLAVE = 2'h3
    } port_mode_t;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int HOLD_LONG_NS = 300;
    localparam int HOLD_SHORT_NS = 100;
    localparam logic [4:0] HOLD_LONG_CYC = 5'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] HOLD_SHORT_CYC = 5'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : ssp_ctl3_pkg

`default_nettype wire

// ---- hdl/serial_port_ctl3_rstart_collision.sv ----
`timescale 1ns/100ps
`default_nettype none

module serial_port_ctl3_rstart_collision
    import ssp_ctl3_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic SPI_SCK,
    input wire logic SPI_SDI,
    output logic START_IRQ,
    output logic STOP_IRQ,
    output logic BUS_COLLISION
);

    // ==========================================================
    // Repeated Start sequencer states
    typedef enum logic [5:0] {
        RS_IDLE = 6'h01,
        RS_SDA_REL = 6'h02,
        RS_WAIT1 = 6'h04,
        RS_SCL_HI = 6'h08,
        RS_WAIT2 = 6'h10,
        RS_SDA_LOW = 6'h20
    } rs_state_t;

    // ==========================================================
    // Registers
    logic [7:0] ctl3;
    logic [1:0] mode;
    logic auto_ss;
    logic [7:0] baud_reload;
    logic [7:0] receive_buffer;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic clock_release_bit;
    logic bus_collision_flag;
    logic ack_phase_flag;

    // Input synchronisers: {sdi, sck, sda, scl}
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;

    // Repeated Start state
    rs_state_t rs_state;
    logic [7:0] baud_rate_generator;
    logic sda_oe_m;
    logic scl_oe_m;
    logic rs_coll;

    // I2C slave state
    logic sl_active;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic is_addr;
    logic addressed;
    logic rw;
    logic [7:0] tx_shift;
    logic tx_bit;
    logic pend_oe;
    logic [4:0] hold_cnt;
    logic sda_oe_s;
    logic sl_coll;
    logic i2c_byte_evt;

    // SPI slave state
    logic [2:0] spi_cnt;
    logic [7:0] spi_shreg;

    // ==========================================================
    // Decoding
    wire scl = sync2[0];
    wire sda = sync2[1];
    wire scl_rise = sync2[0] & ~prev[0];
    wire scl_fall = ~sync2[0] & prev[0];
    wire sda_rise = sync2[1] & ~prev[1];
    wire sda_fall = ~sync2[1] & prev[1];
    wire sck_rise = sync2[2] & ~prev[2];
    wire is_i2c = (mode == MODE_I2C_MASTER) || (mode == MODE_I2C_SLAVE);
    wire i2c_master = (mode == MODE_I2C_MASTER);
    wire i2c_slave = (mode == MODE_I2C_SLAVE);
    wire spi_slave = (mode == MODE_SPI_SLAVE);
    wire wr_ctl3 = WR && (ADDR == REG_CTL3);
    wire wr_ctrl = WR && (ADDR == REG_CTRL);
    wire wr_baud = WR && (ADDR == REG_BAUD);
    wire wr_stat = WR && (ADDR == REG_STAT);
    wire rd_buf = RD && (ADDR == REG_BUF);
    wire rs_go = wr_ctrl && WDATA[CTRL_RS_GO] && i2c_master;
    wire start_det = sda_fall && scl && prev[0];
    wire stop_det = sda_rise && scl && prev[0];
    wire hold_en = ctl3[CTL3_ADDRESS_HOLD_ENABLE] | ctl3[CTL3_DATA_HOLD_ENABLE];
    wire addr_match = (shreg[7:1] == baud_reload[7:1]);
    wire tx_mode = addressed && rw && !is_addr;
    wire byte_done8 = (bit_cnt == BITS_PER_BYTE);
    wire rx_byte_ok = is_addr ? addr_match : (addressed && !rw);
    // Overwrite only matters in slave modes; master modes never reach here
    wire i2c_upd = ctl3[CTL3_BUFFER_OVERWRITE_ENABLE] ? !buffer_full_flag
                                   : (!buffer_full_flag && !receive_overflow_flag);
    wire spi_byte_evt = spi_slave && sck_rise && (spi_cnt == 3'h7);
    wire spi_upd = ctl3[CTL3_BUFFER_OVERWRITE_ENABLE] || !buffer_full_flag;
    wire [7:0] spi_byte = {spi_shreg[6:0], sync2[3]};
    wire ss_irq_ok = is_i2c && !(i2c_slave && auto_ss);
    wire [4:0] hold_cycles = ctl3[CTL3_SDA_HOLD_SELECT] ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
    wire slave_hold = i2c_slave && !clock_release_bit;
    wire next_scl_oe = i2c_master ? scl_oe_m : slave_hold;
    wire next_sda_oe = i2c_master ? sda_oe_m : (i2c_slave && sda_oe_s);
    wire [7:0] stat_rd = {3'h0, (rs_state != RS_IDLE), bus_collision_flag, clock_release_bit,
                          receive_overflow_flag, buffer_full_flag};
    wire [7:0] ctl3_rd = {ack_phase_flag & hold_en, ctl3[6:0]};
    wire [7:0] next_rdata = (ADDR == REG_CTL3) ? ctl3_rd :
                            (ADDR == REG_CTRL) ? {5'h00, auto_ss, mode} :
                            (ADDR == REG_BAUD) ? baud_reload :
                            (ADDR == REG_STAT) ? stat_rd :
                            (ADDR == REG_BUF) ? receive_buffer : 8'h00;

    // ==========================================================
    // Pin synchronisers, two stages then an edge register
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            prev <= 4'hF;
        end else begin
            sync1 <= {SPI_SDI, SPI_SCK, SDA_I, SCL_I};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // ==========================================================
    // Software control registers
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl3 <= CTL3_RESET;
            mode <= MODE_RESET;
            auto_ss <= 1'b0;
            baud_reload <= BAUD_RESET;
        end else begin
            if (wr_ctl3) begin
                ctl3 <= {1'b0, WDATA[6:0]}; // Bit 7 is status only
            end
            if (wr_ctrl) begin
                mode <= WDATA[1:0];
                auto_ss <= WDATA[CTRL_AUTO_SS];
            end
            if (wr_baud) begin
                baud_reload <= WDATA;
            end
        end
    end

    // ==========================================================
    // Repeated Start sequencer with collision checks
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rs_state <= RS_IDLE;
            baud_rate_generator <= 8'h00;
            sda_oe_m <= 1'b0;
            scl_oe_m <= 1'b0;
            rs_coll <= 1'b0;
        end else begin
            rs_coll <= 1'b0;
            unique case (rs_state)
                RS_IDLE: begin
                    if (rs_go) begin
                        sda_oe_m <= 1'b0; // Release SDA, keep SCL low
                        scl_oe_m <= 1'b1;
                        rs_state <= RS_SDA_REL;
                    end
                end
                RS_SDA_REL: begin
                    if (sda) begin
                        baud_rate_generator <= baud_reload;
                        rs_state <= RS_WAIT1;
                    end
                end
                RS_WAIT1: begin
                    if (baud_rate_generator == 8'h00) begin
                        scl_oe_m <= 1'b0;
                        rs_state <= RS_SCL_HI;
                    end else begin
                        baud_rate_generator <= baud_rate_generator - 8'h01;
                    end
                end
                RS_SCL_HI: begin
                    if (scl && !sda) begin
                        rs_coll <= 1'b1;
                        sda_oe_m <= 1'b0;
                        scl_oe_m <= 1'b0;
                        rs_state <= RS_IDLE;
                    end else if (scl) begin
                        baud_rate_generator <= baud_reload;
                        rs_state <= RS_WAIT2;
                    end
                end
                RS_WAIT2: begin
                    // SDA falling here is another master's start, not a collision
                    if (scl_fall && !sda_oe_m) begin
                        rs_coll <= 1'b1;
                        sda_oe_m <= 1'b0;
                        scl_oe_m <= 1'b0;
                        rs_state <= RS_IDLE;
                    end else if (baud_rate_generator == 8'h00) begin
                        sda_oe_m <= 1'b1;
                        baud_rate_generator <= baud_reload;
                        rs_state <= RS_SDA_LOW;
                    end else begin
                        baud_rate_generator <= baud_rate_generator - 8'h01;
                    end
                end
                RS_SDA_LOW: begin
                    if (baud_rate_generator == 8'h00) begin
                        scl_oe_m <= 1'b1;
                        rs_state <= RS_IDLE;
                    end else begin
                        baud_rate_generator <= baud_rate_generator - 8'h01;
                    end
                end
                default: begin
                    rs_state <= RS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // I2C slave receive/transmit engine
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sl_active <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            is_addr <= 1'b0;
            addressed <= 1'b0;
            rw <= 1'b0;
            tx_shift <= 8'h00;
            tx_bit <= 1'b1;
            pend_oe <= 1'b0;
            hold_cnt <= 5'h00;
            sda_oe_s <= 1'b0;
            sl_coll <= 1'b0;
            ack_phase_flag <= 1'b0;
            i2c_byte_evt <= 1'b0;
        end else begin
            sl_coll <= 1'b0;
            i2c_byte_evt <= 1'b0;
            if (hold_cnt != 5'h00) begin
                hold_cnt <= hold_cnt - 5'h01;
                if (hold_cnt == 5'h01) begin
                    sda_oe_s <= pend_oe;
                end
            end
            if (!i2c_slave || stop_det) begin
                sl_active <= 1'b0;
                sda_oe_s <= 1'b0;
                addressed <= 1'b0;
                ack_phase_flag <= 1'b0;
            end else if (start_det) begin
                sl_active <= 1'b1;
                bit_cnt <= 4'h0;
                is_addr <= 1'b1;
                addressed <= 1'b0;
                ack_phase_flag <= 1'b0;
            end else if (sl_active && scl_rise) begin
                if (tx_mode && !byte_done8 && tx_bit && !sda && ctl3[CTL3_SLAVE_COLLISION_ENABLE]) begin
                    sl_coll <= 1'b1;
                    sl_active <= 1'b0;
                    sda_oe_s <= 1'b0;
                    hold_cnt <= 5'h00;
                    addressed <= 1'b0;
                end else if (byte_done8) begin
                    ack_phase_flag <= 1'b0;
                    bit_cnt <= 4'h0;
                    is_addr <= 1'b0;
                end else begin
                    shreg <= {shreg[6:0], sda};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (sl_active && scl_fall) begin
                hold_cnt <= hold_cycles;
                if (byte_done8) begin
                    ack_phase_flag <= hold_en;
                    pend_oe <= 1'b0;
                    if (rx_byte_ok && !(tx_mode)) begin
                        i2c_byte_evt <= 1'b1;
                        pend_oe <= i2c_upd;
                    end
                    if (is_addr) begin
                        addressed <= addr_match;
                        rw <= shreg[0];
                        tx_shift <= receive_buffer;
                    end
                end else if (tx_mode) begin
                    pend_oe <= !tx_shift[7];
                    tx_bit <= tx_shift[7];
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end else begin
                    pend_oe <= 1'b0;
                    tx_bit <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // SPI slave shifter
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            spi_cnt <= 3'h0;
            spi_shreg <= 8'h00;
        end else if (!spi_slave) begin
            spi_cnt <= 3'h0;
        end else if (sck_rise) begin
            spi_shreg <= spi_byte;
            spi_cnt <= spi_cnt + 3'h1;
        end
    end

    // ==========================================================
    // Receive buffer, buffer-full and overflow; hardware set wins over clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            receive_buffer <= 8'h00;
            buffer_full_flag <= 1'b0;
            receive_overflow_flag <= 1'b0;
        end else begin
            if (rd_buf) begin
                buffer_full_flag <= 1'b0;
            end
            if (wr_stat && WDATA[STAT_OV]) begin
                receive_overflow_flag <= 1'b0;
            end
            if (spi_byte_evt) begin
                if (buffer_full_flag) begin
                    receive_overflow_flag <= 1'b1;
                end
                if (spi_upd) begin
                    receive_buffer <= spi_byte;
                    buffer_full_flag <= 1'b1;
                end
            end else if (i2c_byte_evt) begin
                if (buffer_full_flag) begin
                    receive_overflow_flag <= 1'b1;
                end
                if (pend_oe) begin
                    receive_buffer <= shreg;
                    buffer_full_flag <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Clock release bit and collision flag
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clock_release_bit <= CKP_RESET;
            bus_collision_flag <= 1'b0;
        end else begin
            if (i2c_byte_evt && !is_addr && ctl3[CTL3_DATA_HOLD_ENABLE]) begin
                clock_release_bit <= 1'b0;
            end else if (i2c_byte_evt && is_addr && ctl3[CTL3_ADDRESS_HOLD_ENABLE]) begin
                clock_release_bit <= 1'b0;
            end else if (wr_stat) begin
                clock_release_bit <= WDATA[STAT_CKP];
            end
            if (rs_coll || sl_coll) begin
                bus_collision_flag <= 1'b1;
            end else if (wr_stat && WDATA[STAT_BCL]) begin
                bus_collision_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 8'h00;
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
            START_IRQ <= 1'b0;
            STOP_IRQ <= 1'b0;
            BUS_COLLISION <= 1'b0;
        end else begin
            RDATA <= RD ? next_rdata : 8'h00;
            SCL_O <= 1'b0; // Open drain: only ever pulls low
            SDA_O <= 1'b0;
            SCL_OE <= next_scl_oe;
            SDA_OE <= next_sda_oe;
            START_IRQ <= start_det && ss_irq_ok && ctl3[CTL3_START_IE];
            STOP_IRQ <= stop_det && ss_irq_ok && ctl3[CTL3_STOP_IE];
            BUS_COLLISION <= bus_collision_flag;
        end
    end

endmodule : serial_port_ctl3_rstart_collision

`default_nettype wire
